// *** acs_defines.svh ***
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define ACS_OFF_MODE0 8'h00
`define ACS_OFF_MODE1 8'h04
`define ACS_OFF_MODE2 8'h08
`define ACS_OFF_SELECT 8'h0C
`define ACS_OFF_RESULT0 8'h10
`define ACS_OFF_RESULT1 8'h14
`define ACS_OFF_RESULT2 8'h18
`define ACS_OFF_RESULT3 8'h1C

// ==========================================================================
// Field positions
`define ACS_M0_ENABLE 7
`define ACS_M0_ACTIVE 6
`define ACS_M0_ONESHOT 5
`define ACS_M0_SCAN 4
`define ACS_M0_EDGE_HI 3
`define ACS_M0_EDGE_LO 2
`define ACS_M0_HW_TRIG 1
`define ACS_M1_RATIO_HI 1
`define ACS_M1_RATIO_LO 0
`define ACS_M2_TIMER_SEL 0
`define ACS_SEL_BUF4 4

// ==========================================================================
// Reset values
`define ACS_RST_MODE0 8'h00
`define ACS_RST_MODE1 8'h01
`define ACS_RST_MODE2 8'h00
`define ACS_RST_SELECT 8'h00
`define ACS_RST_RESULT 10'h000

// ==========================================================================
// Standby encodings
`define ACS_SBY_RUN 2'h0
`define ACS_SBY_HALT 2'h1
`define ACS_SBY_IDLE 2'h2
`define ACS_SBY_STOP 2'h3

// ==========================================================================
// Phase clock counts per ratio setting
`define ACS_INIT_01 8'd2
`define ACS_INIT_10 8'd3
`define ACS_INIT_11 8'd4
`define ACS_SAMP1_01 8'd16
`define ACS_SAMP1_10 8'd24
`define ACS_SAMP1_11 8'd32
`define ACS_SAMP2_01 8'd18
`define ACS_SAMP2_10 8'd27
`define ACS_SAMP2_11 8'd36

// ==========================================================================
// Stabilization time
`define ACS_CLK_PERIOD_NS 4
`define ACS_STAB_TIME_NS 1000
`define ACS_STAB_CYCLES \
  ((`ACS_STAB_TIME_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)

`endif

// *** acs_pkg.sv ***
package acs_pkg;

  // ========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ACS_OFF,
    ACS_STAB,
    ACS_WAIT,
    ACS_INIT,
    ACS_SAMP1,
    ACS_SAMP2
  } acs_state_e;

endpackage : acs_pkg

// *** acs_sequencer.sv ***
// Functional notes
// - Start runs 2/3/4 initialization clocks first
// - First sampling lasts 16/24/32 clocks
// - Second sampling lasts 18/27/36 clocks
// - Clearing enable aborts, nothing stored
// - Hardware never clears the enable bit
// - Trigger during conversion aborts and restarts
// - Spaced triggers complete with result and interrupt
// - Halt standby keeps converting
// - Idle/stop freeze sequencer, registers hold
// - Suspended conversion resumes on wake
// - Timer trigger also forwarded as interrupt
// - Write or trigger at stabilization end restarts
// - One-shot software race: store write, stop quietly
// - Writing enable 1 restarts after race
// - Race in scan keeps earlier channel results
// - Active flag high only while converting
// - Mode0, mode2 or select write aborts to stabilization, or to off if disabled
// - Scan converts channels upward from zero
`timescale 1ns/1ns
`include "acs_defines.svh"

module acs_sequencer
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  input wire logic timer_conv_trigger_i,
  input wire logic external_trigger_pin_i,
  input wire logic [1:0] standby_mode_i,
  input wire logic [9:0] conv_data_i,
  output logic [1:0] analog_channel_o,
  output logic sampling_o,
  output logic conversion_done_irq_o,
  output logic timer_irq_o
);
  import acs_pkg::*;

  // ========================================================================
  // Declarations
  acs_state_e state_q;
  acs_state_e state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [1:0] idx_q;
  logic [1:0] idx_d;
  logic store_d;
  logic done_d;
  logic [7:0] adc_mode_reg0_q;
  logic [7:0] adc_mode_reg1_q;
  logic [7:0] adc_mode_reg2_q;
  logic [7:0] channel_select_reg_q;
  logic [9:0] conversion_result_reg_q [4];
  logic [15:0] rdata_q;
  logic done_q;
  logic timer_irq_q;
  logic [1:0] chan_q;
  logic sampling_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic ext_lvl_q;
  logic ext_prev_q;
  logic wr_mode0;
  logic wr_mode1;
  logic wr_mode2;
  logic wr_select;
  logic mode_wr;
  logic new_enable;
  logic conv_enable_bit;
  logic conv_active_flag;
  logic hw_trig;
  logic timer_sel;
  logic ext_edge;
  logic trig;
  logic gated;
  logic scan;
  logic buf4;
  logic oneshot;
  logic last_conv;
  logic race;
  logic [1:0] ratio;
  logic [1:0] ridx;
  logic [1:0] chan_d;

  // ========================================================================
  // Phase lengths from the ratio setting
  function automatic logic [7:0] init_len(input logic [1:0] r);
    case (r)
      2'h1: init_len = `ACS_INIT_01;
      2'h2: init_len = `ACS_INIT_10;
      default: init_len = `ACS_INIT_11;
    endcase
  endfunction : init_len

  function automatic logic [7:0] samp1_len(input logic [1:0] r);
    case (r)
      2'h1: samp1_len = `ACS_SAMP1_01;
      2'h2: samp1_len = `ACS_SAMP1_10;
      default: samp1_len = `ACS_SAMP1_11;
    endcase
  endfunction : samp1_len

  function automatic logic [7:0] samp2_len(input logic [1:0] r);
    case (r)
      2'h1: samp2_len = `ACS_SAMP2_01;
      2'h2: samp2_len = `ACS_SAMP2_10;
      default: samp2_len = `ACS_SAMP2_11;
    endcase
  endfunction : samp2_len

  // ========================================================================
  // Register write decode and mode fields
  assign wr_mode0 = reg_write_i && (reg_addr_i == `ACS_OFF_MODE0);
  assign wr_mode1 = reg_write_i && (reg_addr_i == `ACS_OFF_MODE1);
  assign wr_mode2 = reg_write_i && (reg_addr_i == `ACS_OFF_MODE2);
  assign wr_select = reg_write_i && (reg_addr_i == `ACS_OFF_SELECT);
  assign mode_wr = wr_mode0 || wr_mode2 || wr_select;
  assign conv_enable_bit = adc_mode_reg0_q[`ACS_M0_ENABLE];
  assign new_enable = wr_mode0 ? reg_wdata_i[`ACS_M0_ENABLE]
                               : conv_enable_bit;
  assign hw_trig = adc_mode_reg0_q[`ACS_M0_HW_TRIG];
  assign oneshot = adc_mode_reg0_q[`ACS_M0_ONESHOT];
  assign scan = adc_mode_reg0_q[`ACS_M0_SCAN];
  assign timer_sel = adc_mode_reg2_q[`ACS_M2_TIMER_SEL];
  assign buf4 = channel_select_reg_q[`ACS_SEL_BUF4] && !scan;
  assign ratio = {adc_mode_reg1_q[`ACS_M1_RATIO_HI],
                  adc_mode_reg1_q[`ACS_M1_RATIO_LO]};
  assign conv_active_flag = (state_q == ACS_INIT) ||
                            (state_q == ACS_SAMP1) ||
                            (state_q == ACS_SAMP2);
  assign gated = (standby_mode_i == `ACS_SBY_IDLE) ||
                 (standby_mode_i == `ACS_SBY_STOP);

  // Trigger select and scan bookkeeping
  assign trig = hw_trig && (timer_sel ? timer_conv_trigger_i : ext_edge);
  assign last_conv = scan ? (idx_q == channel_select_reg_q[1:0])
                          : (!buf4 || idx_q == 2'h3);
  assign ridx = (scan || buf4) ? idx_q : channel_select_reg_q[1:0];
  assign race = mode_wr && oneshot && !hw_trig && last_conv &&
                (state_q == ACS_SAMP2) && (cnt_q == 8'h00);

  // ========================================================================
  // External trigger pin: three-stage sync and edge select
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      ext_lvl_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_s1_q <= external_trigger_pin_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      if (ext_s2_q == ext_s3_q)
      begin
        ext_lvl_q <= ext_s3_q;
      end
      ext_prev_q <= ext_lvl_q;
    end
  end

  // Falling, rising, or both edges
  always_comb
  begin
    case ({adc_mode_reg0_q[`ACS_M0_EDGE_HI],
           adc_mode_reg0_q[`ACS_M0_EDGE_LO]})
      2'h0: ext_edge = ext_prev_q && !ext_lvl_q;
      2'h1: ext_edge = !ext_prev_q && ext_lvl_q;
      default: ext_edge = ext_prev_q != ext_lvl_q;
    endcase
  end

  // ========================================================================
  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    store_d = 1'b0;
    done_d = 1'b0;
    if (!gated)
    begin
      // Phase counter runs only while the clock is supplied
      if (cnt_q != 8'h00)
      begin
        cnt_d = cnt_q - 8'h01;
      end
      case (state_q)
        ACS_OFF:
        begin
          state_d = ACS_OFF;
        end
        ACS_STAB:
        begin
          if (cnt_q == 8'h00)
          begin
            if (reg_write_i || trig)
            begin
              cnt_d = 8'(`ACS_STAB_CYCLES - 1);
            end
            else if (!hw_trig)
            begin
              state_d = ACS_INIT;
              cnt_d = init_len(ratio) - 8'h01;
              idx_d = 2'h0;
            end
            else
            begin
              state_d = ACS_WAIT;
            end
          end
        end
        ACS_WAIT:
        begin
          if (trig)
          begin
            state_d = ACS_INIT;
            cnt_d = init_len(ratio) - 8'h01;
            idx_d = 2'h0;
          end
        end
        ACS_INIT:
        begin
          if (cnt_q == 8'h00)
          begin
            state_d = ACS_SAMP1;
            cnt_d = samp1_len(ratio) - 8'h01;
          end
        end
        ACS_SAMP1:
        begin
          if (cnt_q == 8'h00)
          begin
            state_d = ACS_SAMP2;
            cnt_d = samp2_len(ratio) - 8'h01;
          end
        end
        ACS_SAMP2:
        begin
          if (cnt_q == 8'h00)
          begin
            store_d = 1'b1;
            state_d = ACS_INIT;
            cnt_d = init_len(ratio) - 8'h01;
            if (!last_conv)
            begin
              idx_d = idx_q + 2'h1;
            end
            else
            begin
              done_d = 1'b1;
              idx_d = 2'h0;
              if (hw_trig || oneshot)
              begin
                state_d = ACS_WAIT;
              end
            end
          end
        end
        default:
        begin
          state_d = ACS_OFF;
        end
      endcase
      // Hardware trigger mid-conversion restarts from the top
      if (conv_active_flag && trig)
      begin
        state_d = ACS_INIT;
        cnt_d = init_len(ratio) - 8'h01;
        idx_d = 2'h0;
        store_d = 1'b0;
        done_d = 1'b0;
      end
      // Reserved ratio never begins a conversion
      if (ratio == 2'h0 && state_d == ACS_INIT)
      begin
        state_d = ACS_WAIT;
        store_d = 1'b0;
        done_d = 1'b0;
      end
      // Mode0, mode2 or select writes abort the running conversion
      if (mode_wr)
      begin
        store_d = 1'b0;
        done_d = 1'b0;
        idx_d = 2'h0;
        if (race)
        begin
          state_d = ACS_WAIT;
        end
        else if (new_enable)
        begin
          state_d = ACS_STAB;
          cnt_d = 8'(`ACS_STAB_CYCLES - 1);
        end
        else
        begin
          state_d = ACS_OFF;
        end
      end
    end
  end

  // Channel presented to the analog mux
  assign chan_d = ((scan || buf4) ? idx_d : 2'h0) |
                  ((scan || buf4) ? 2'h0 : channel_select_reg_q[1:0]);

  // ========================================================================
  // Sequencer registers
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ACS_OFF;
      cnt_q <= 8'h00;
      idx_q <= 2'h0;
      done_q <= 1'b0;
      chan_q <= 2'h0;
      sampling_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      done_q <= done_d;
      chan_q <= scan ? idx_d : chan_d;
      sampling_q <= (state_d == ACS_INIT) || (state_d == ACS_SAMP1) ||
                    (state_d == ACS_SAMP2);
    end
  end

  // Timer trigger forwarded as a processor interrupt
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      timer_irq_q <= 1'b0;
    end
    else
    begin
      timer_irq_q <= timer_conv_trigger_i && hw_trig && timer_sel;
    end
  end

  // ========================================================================
  // Mode and select registers: only software changes them
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      adc_mode_reg0_q <= `ACS_RST_MODE0;
      adc_mode_reg1_q <= `ACS_RST_MODE1;
      adc_mode_reg2_q <= `ACS_RST_MODE2;
      channel_select_reg_q <= `ACS_RST_SELECT;
    end
    else
    begin
      if (wr_mode0)
      begin
        adc_mode_reg0_q <= reg_wdata_i[7:0] &
                           ~(8'h01 << `ACS_M0_ACTIVE);
      end
      if (wr_mode1)
      begin
        adc_mode_reg1_q <= reg_wdata_i[7:0];
      end
      if (wr_mode2)
      begin
        adc_mode_reg2_q <= reg_wdata_i[7:0];
      end
      if (wr_select)
      begin
        channel_select_reg_q <= reg_wdata_i[7:0];
      end
    end
  end

  // Result registers, one per entry
  for (genvar m = 0; m < 4; m++)
  begin : g_result
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        conversion_result_reg_q[m] <= `ACS_RST_RESULT;
      end
      else if (store_d && ridx == 2'(m))
      begin
        conversion_result_reg_q[m] <= conv_data_i;
      end
    end
  end

  // ========================================================================
  // Read port: data one cycle after the strobe, zero when unmapped
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q <= 16'h0000;
    end
    else if (reg_read_i)
    begin
      case (reg_addr_i)
        `ACS_OFF_MODE0: rdata_q <= {8'h00, conv_enable_bit,
                                    conv_active_flag,
                                    adc_mode_reg0_q[5:0]};
        `ACS_OFF_MODE1: rdata_q <= {8'h00, adc_mode_reg1_q};
        `ACS_OFF_MODE2: rdata_q <= {8'h00, adc_mode_reg2_q};
        `ACS_OFF_SELECT: rdata_q <= {8'h00, channel_select_reg_q};
        `ACS_OFF_RESULT0: rdata_q <= {6'h00, conversion_result_reg_q[0]};
        `ACS_OFF_RESULT1: rdata_q <= {6'h00, conversion_result_reg_q[1]};
        `ACS_OFF_RESULT2: rdata_q <= {6'h00, conversion_result_reg_q[2]};
        `ACS_OFF_RESULT3: rdata_q <= {6'h00, conversion_result_reg_q[3]};
        default: rdata_q <= 16'h0000;
      endcase
    end
    else
    begin
      rdata_q <= 16'h0000;
    end
  end

  // ========================================================================
  // Outputs
  assign reg_rdata_o = rdata_q;
  assign analog_channel_o = chan_q;
  assign sampling_o = sampling_q;
  assign conversion_done_irq_o = done_q;
  assign timer_irq_o = timer_irq_q;

endmodule : acs_sequencer

// *** acs_sequencer_chk.sv ***
`timescale 1ns/1ns
// ==========================================================================
// Port checker for the conversion sequencer
module acs_sequencer_chk
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic timer_conv_trigger_i,
  input wire logic [1:0] standby_mode_i,
  input wire logic sampling_o,
  input wire logic conversion_done_irq_o,
  input wire logic timer_irq_o
);
  logic [7:0] run_q;
  logic [1:0] ratio_q;
  logic en_q;

  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // Length of the current active run, saturating
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      run_q <= 8'h00;
    else if (!sampling_o)
      run_q <= 8'h00;
    else if (run_q != 8'hFF)
      run_q <= run_q + 8'h01;
  end

  // Shadow of the ratio field
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ratio_q <= 2'h1;
    else if (reg_write_i && reg_addr_i == 8'h04)
      ratio_q <= reg_wdata_i[1:0];
  end

  // Shadow of the enable bit, only software moves it
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      en_q <= 1'b0;
    else if (reg_write_i && reg_addr_i == 8'h00)
      en_q <= reg_wdata_i[7];
  end

  // ==========================================================================
  // Request shapes
  sequence ctl_write_s;
    reg_write_i && reg_addr_i inside {8'h00, 8'h08, 8'h0C};
  endsequence

  sequence mode0_read_s;
    reg_read_i && reg_addr_i == 8'h00;
  endsequence

  // ==========================================================================
  // Properties
  chk_done_pulse: assert property (
    conversion_done_irq_o |=> !conversion_done_irq_o)
    else $error("completion pulse too long");
  chk_done_span: assert property (
    conversion_done_irq_o |-> run_q >= 8'd36)
    else $error("completion after too short a run");
  chk_timer_echo: assert property (
    timer_irq_o |-> $past(timer_conv_trigger_i))
    else $error("timer interrupt without trigger");
  chk_read_quiet: assert property (
    !$past(reg_read_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside answer cycle");
  chk_freeze_hold: assert property (
    (standby_mode_i[1]) [*3] |-> $stable(sampling_o)
      && !conversion_done_irq_o)
    else $error("sequencer moved in deep standby");
  chk_ratio_resv: assert property (
    $rose(sampling_o) |-> $past(ratio_q) != 2'h0)
    else $error("conversion started with reserved ratio");
  chk_enable_kept: assert property (
    mode0_read_s |=> reg_rdata_o[7] == en_q)
    else $error("enable bit changed by hardware");
  chk_write_abort: assert property (
    ctl_write_s |=> (!conversion_done_irq_o) [*8])
    else $error("completion after control write");
endmodule : acs_sequencer_chk

bind acs_sequencer acs_sequencer_chk u_chk
(
  .clock_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
  .reg_read_i, .reg_rdata_o, .timer_conv_trigger_i, .standby_mode_i,
  .sampling_o, .conversion_done_irq_o, .timer_irq_o
);

// *** acs_far_side.sv ***
`timescale 1ns/1ns
// ==========================================================================
// Timer trigger, trigger pin and analog inputs
module acs_far_side
#(
  parameter int GAP_MIN = 72
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic fire_i,
  input wire logic force_i,
  input wire logic flip_i,
  input wire logic [7:0] level_i,
  input wire logic [1:0] channel_i,
  input wire logic sampling_i,
  output logic trig_o,
  output logic pin_o,
  output logic [9:0] data_o
);
  logic [7:0] gap_q;
  logic [9:0] churn_q;

  // Timer pulse, held back while the last one is too recent
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      trig_o <= 1'b0;
    else
      trig_o <= fire_i && (gap_q >= 8'(GAP_MIN) || force_i);
  end

  // Cycles since the last timer pulse
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      gap_q <= 8'hFF;
    else if (trig_o)
      gap_q <= 8'h00;
    else if (gap_q != 8'hFF)
      gap_q <= gap_q + 8'h01;
  end

  // Trigger pin level and an input that wanders when not held
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_o <= 1'b0;
      churn_q <= 10'h000;
    end
    else
    begin
      pin_o <= pin_o ^ flip_i;
      churn_q <= churn_q + 10'h3A7;
    end
  end

  // Channel and level while sampled, noise otherwise
  assign data_o = sampling_i ? {channel_i, level_i} : churn_q;
endmodule : acs_far_side

// *** acs_sequencer_test.sv ***
`timescale 1ns/1ns
`include "acs_defines.svh"
// ==========================================================================
// Self-checking bench for the conversion sequencer
module acs_sequencer_test;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [1:0] standby_mode_i = 2'h0;
  logic fire = 1'b0;
  logic force_on = 1'b0;
  logic flip = 1'b0;
  logic [7:0] level = 8'h00;
  logic [15:0] reg_rdata_o;
  logic timer_conv_trigger_i;
  logic external_trigger_pin_i;
  logic [9:0] conv_data_i;
  logic [1:0] analog_channel_o;
  logic sampling_o;
  logic conversion_done_irq_o;
  logic timer_irq_o;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int dones = 0;
  int tirqs = 0;
  int n;
  int m;
  logic [31:0] seed = 32'h000168EF;
  logic [15:0] d;
  logic [15:0] keep;
  logic [7:0] tot;
  logic [1:0] ch;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
  logic [15:0] rv [6] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000,
    16'h0000, 16'h0000};

  always #2 clock_i = ~clock_i;

  acs_sequencer u_dut
  (
    .clock_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
    .reg_read_i, .reg_rdata_o, .timer_conv_trigger_i,
    .external_trigger_pin_i, .standby_mode_i, .conv_data_i,
    .analog_channel_o, .sampling_o, .conversion_done_irq_o, .timer_irq_o
  );

  acs_far_side u_far
  (
    .clock_i, .rst_n_i, .fire_i(fire), .force_i(force_on), .flip_i(flip),
    .level_i(level), .channel_i(analog_channel_o), .sampling_i(sampling_o),
    .trig_o(timer_conv_trigger_i), .pin_o(external_trigger_pin_i),
    .data_o(conv_data_i)
  );

  // Count interrupt pulses and cut a hang short
  always @(negedge clock_i)
  begin
    dones += int'(conversion_done_irq_o);
    tirqs += int'(timer_irq_o);
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      results();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Active cycles: initialization, first and second sampling
  function automatic logic [7:0] span(input logic [1:0] r);
    case (r)
      2'h1: return 8'd2 + 8'd16 + 8'd18;
      2'h2: return 8'd3 + 8'd24 + 8'd27;
      default: return 8'd4 + 8'd32 + 8'd36;
    endcase
  endfunction : span

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_write_i <= 1'b1;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    @(negedge clock_i);
    d = reg_rdata_o;
  endtask : rd

  // Timer pulse; returns in the cycle the pulse is seen
  task automatic shot(input logic f);
    @(posedge clock_i);
    fire <= 1'b1;
    force_on <= f;
    @(posedge clock_i);
    fire <= 1'b0;
    @(negedge clock_i);
  endtask : shot

  task automatic pin();
    @(posedge clock_i);
    flip <= 1'b1;
    @(posedge clock_i);
    flip <= 1'b0;
  endtask : pin

  task automatic wdone();
    n = 0;
    do
    begin
      @(negedge clock_i);
      n++;
    end
    while (conversion_done_irq_o !== 1'b1 && n < 700);
  endtask : wdone

  task automatic roll();
    seed = lfsr(seed);
    ch = seed[9:8];
    @(posedge clock_i);
    level <= seed[7:0];
  endtask : roll

  task automatic results();
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(ra[i]);
      chk(d, rv[i]);
    end
    for (int r = 1; r < 4; r++)
    begin
      roll();
      tot = span(2'(r));
      wr(8'h04, 16'(r));
      wr(8'h08, 16'h0001);
      wr(8'h0C, {14'h0, ch});
      wr(8'h00, 16'h0082);
      repeat (260) @(posedge clock_i);
      shot(1'b0);
      wdone();
      chk(16'(n), {8'h00, tot} + 16'h0001);
      rd(8'h10 + {4'h0, ch, 2'h0});
      chk(d, {6'h00, ch, level});
      rd(8'h00);
      chk(d, 16'h0082);
      chk(16'(tirqs), 16'(r));
    end
    // Clearing enable mid-run drops the conversion
    keep = {6'h00, ch, level};
    m = dones;
    shot(1'b0);
    level <= ~level;
    wr(8'h00, 16'h0002);
    repeat (100) @(negedge clock_i);
    chk(16'(dones - m), 16'h0000);
    rd(8'h10 + {4'h0, ch, 2'h0});
    chk(d, keep);
    // Second trigger mid-run restarts from it
    wr(8'h00, 16'h0082);
    repeat (260) @(posedge clock_i);
    m = dones;
    shot(1'b0);
    repeat (20) @(posedge clock_i);
    shot(1'b1);
    wdone();
    chk(16'(n), {8'h00, tot} + 16'h0001);
    @(negedge clock_i);
    chk(16'(dones - m), 16'h0001);
    // Halt keeps running, idle and stop freeze for 40 cycles
    for (int s = 1; s < 4; s++)
    begin
      shot(1'b0);
      fork
        wdone();
        begin
          @(posedge clock_i);
          standby_mode_i <= 2'(s);
          repeat (40) @(posedge clock_i);
          standby_mode_i <= 2'h0;
        end
      join
      chk(16'(n),
          {8'h00, tot} + 16'h0001 + (s > 1 ? 16'd40 : 16'd0));
      rd(8'h04);
      chk(d, 16'h0003);
    end
    // Pin trigger on both edges, then the reserved ratio
    wr(8'h08, 16'h0000);
    wr(8'h00, 16'h008A);
    repeat (260) @(posedge clock_i);
    pin();
    wdone();
    chk({15'h0, conversion_done_irq_o}, 16'h0001);
    wr(8'h04, 16'h0000);
    m = dones;
    pin();
    repeat (10) @(negedge clock_i);
    chk({15'h0, sampling_o}, 16'h0000);
    repeat (90) @(negedge clock_i);
    chk(16'(dones - m), 16'h0000);
    // One-shot software scan over four channels
    wr(8'h04, 16'h0001);
    roll();
    wr(8'h0C, 16'h0003);
    m = dones;
    wr(8'h00, 16'h00B0);
    wdone();
    repeat (100) @(negedge clock_i);
    chk(16'(dones - m), 16'h0001);
    for (int c = 0; c < 4; c++)
    begin
      rd(8'h10 + 8'(4 * c));
      chk(d, {6'h00, 2'(c), level});
    end
    // Write landing on the last cycle of a two-channel scan
    wr(8'h0C, 16'h0001);
    keep = {6'h00, 2'h1, level};
    level <= ~level;
    m = dones;
    wr(8'h00, 16'h00B0);
    for (int k = 0; k < 400 && sampling_o !== 1'b1; k++)
      @(negedge clock_i);
    repeat (70) @(posedge clock_i);
    wr(8'h00, 16'h00B0);
    repeat (60) @(negedge clock_i);
    chk(16'(dones - m), 16'h0000);
    rd(8'h00);
    chk(d, 16'h00B0);
    rd(8'h10);
    chk(d, {6'h00, 2'h0, level});
    rd(8'h14);
    chk(d, keep);
    wr(8'h00, 16'h00B0);
    // Write landing on the end of stabilization inserts it again
    repeat (248) @(posedge clock_i);
    wr(8'h04, 16'h0001);
    wdone();
    chk(16'(n),
        16'(`ACS_STAB_CYCLES) + 16'(2 * span(2'h1)) + 16'd1);
    chk({15'h0, conversion_done_irq_o}, 16'h0001);
    results();
  end
endmodule : acs_sequencer_test
